// *** core/crw_pkg.sv ***
package crw_pkg;
    // clock rate
    localparam int CLK_PERIOD_NS = 10;
    // clock monitor delay window, longest time, rounded down
    localparam int CM_DELAY_NS = 2000;
    localparam logic [15:0] CM_DELAY_CYC = 16'(CM_DELAY_NS / CLK_PERIOD_NS);
    // clock quality check window and pass criterion
    localparam int QC_WINDOW_NS = 4000;
    localparam logic [23:0] QC_WINDOW_CYC =
        24'((QC_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] QC_MIN_EDGES = 8'h08;
    localparam logic [5:0] QC_MAX_WINDOWS = 6'h32;
    // reset pin low time plus synchroniser latency
    localparam logic [7:0] RST_LOW_CYC = 8'h80;
    localparam logic [7:0] RST_SYNC_CYC = 8'h03;
    localparam logic [7:0] RST_TOTAL_CYC = RST_LOW_CYC + RST_SYNC_CYC;
    // watchdog service keys
    localparam logic [7:0] WDOG_KEY1 = 8'h55;
    localparam logic [7:0] WDOG_KEY2 = 8'haa;
    // timer width
    localparam int TMR_W = 24;
    // quality check states
    typedef enum logic {QC_IDLE, QC_RUN} crw_qc_state_t;
endpackage : crw_pkg

// *** core/crw_timer.sv ***
`timescale 1ns/10ps
module crw_timer #(
    parameter int W = 24
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // control
    input wire logic restart_i,
    input wire logic run_i,
    input wire logic [W-1:0] limit_i,
    // status
    output logic expire_o,
    output logic [W-1:0] count_o
);
    logic [W-1:0] count_reg;

    // expiry on the last count of the period
    assign expire_o = run_i && !restart_i && (count_reg == limit_i - W'(1));
    assign count_o = count_reg;

    // period counter, restart has priority
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_reg <= '0;
        end else if (restart_i || expire_o) begin
            count_reg <= '0;
        end else if (run_i) begin
            count_reg <= count_reg + W'(1);
        end
    end
endmodule : crw_timer

// *** core/crw_flag.sv ***
`timescale 1ns/10ps
module crw_flag (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // event, clear and enable
    input wire logic set_i,
    input wire logic clr_i,
    input wire logic en_i,
    // flag and request
    output logic flag_o,
    output logic irq_o
);
    logic flag_reg;

    // sticky flag, set beats a write-one clear
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_reg <= 1'b0;
        end else if (set_i) begin
            flag_reg <= 1'b1;
        end else if (clr_i) begin
            flag_reg <= 1'b0;
        end
    end

    assign flag_o = flag_reg;
    assign irq_o = flag_reg && en_i; // masked request

    AST_FLAG_SET: assert property (
        @(posedge mclk_i) disable iff (!rstn_i) set_i |=> flag_o)
        else $error("flag not set after event");
    AST_FLAG_HOLD: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        flag_o && !clr_i |=> flag_o)
        else $error("flag cleared without software write");
endmodule : crw_flag

// *** core/crw_core.sv ***
// Functional notes
// - correct service restarts watchdog period
// - missed service causes watchdog reset
// - power-up reset checks clock, resets on oscillator
// - fifty failed windows after power-up or undervoltage start reset in self-clock
// - tick elapse requests interrupt unless disabled
// - tick flag set on timeout, write-one clears
// - tick keep bit runs tick in pseudo-stop
// - lock change either way requests masked interrupt
// - lock flag sticky, cleared by writing one
// - self-clock entry and exit both request interrupt
// - failed check, or monitor failure with self-clock enabled, enters self-clock
// - monitor and self-clock enabled, lost clock enters self-clock
// - self-clock flag sticky, masked by its enable
// - no edge within window means monitor failure
// - no failure when disabled or edges arrive
// - monitor switched only by its enable bit
// - monitor failure resets only without self-clock
// - reset pin low 128 plus sync cycles
`timescale 1ns/10ps
module crw_core import crw_pkg::*; #(
    parameter logic [23:0] WDOG_UNIT = 24'h000400,
    parameter logic [23:0] TICK_UNIT = 24'h000100
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // reset sources and power modes
    input wire logic por_event_i,
    input wire logic undervoltage_reset_i,
    input wire logic stop_recover_i,
    input wire logic stop_mode_i,
    input wire logic pseudo_stop_select_i,
    // open-drain reset pin
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    // watchdog
    input wire logic [2:0] wdog_rate_i,
    input wire logic watchdog_arm_wr_i,
    input wire logic [7:0] watchdog_arm_data_i,
    output logic wdog_timeout_o,
    // periodic tick
    input wire logic [3:0] tick_rate_i,
    input wire logic tick_keep_i,
    input wire logic periodic_tick_irq_enable_i,
    input wire logic periodic_tick_flag_clr_i,
    output logic periodic_tick_flag_o,
    output logic periodic_tick_irq_o,
    // loop lock
    input wire logic pll_lock_i,
    input wire logic lock_change_irq_enable_i,
    input wire logic lock_change_flag_clr_i,
    output logic lock_change_flag_o,
    output logic lock_change_irq_o,
    // oscillator clock, monitor and self-clock mode
    input wire logic osc_clock_i,
    input wire logic clock_monitor_enable_i,
    input wire logic self_clock_mode_enable_i,
    input wire logic self_clock_irq_enable_i,
    input wire logic self_clock_change_flag_clr_i,
    output logic self_clock_change_flag_o,
    output logic self_clock_irq_o,
    output logic self_clock_mode_o,
    output logic clock_monitor_fail_o,
    output logic clock_monitor_reset_o,
    output logic quality_check_busy_o
);
    // watchdog signals
    logic wdog_en;
    logic wdog_service;
    logic wdog_expire;
    logic wdog_armed_reg;
    logic [TMR_W-1:0] wdog_count;
    logic wdog_timeout_reg;
    // tick signals
    logic tick_run;
    logic tick_expire;
    logic [TMR_W-1:0] tick_count;
    // lock signals
    logic lock_prev_reg;
    logic lock_change;
    // clock monitor signals
    logic osc_prev_reg;
    logic osc_edge;
    logic [15:0] cm_cnt_reg;
    logic cm_fail;
    logic cm_fail_prev_reg;
    logic cm_event;
    logic cm_reset_reg;
    // quality check signals
    crw_qc_state_t qc_state_reg;
    logic qc_start;
    logic qc_win_end;
    logic qc_valid;
    logic qc_last_fail;
    logic qc_pend_reg;
    logic [7:0] qc_edges_reg;
    logic [5:0] qc_win_reg;
    // self-clock and reset sequence signals
    logic scm_reg;
    logic scm_set;
    logic scm_clr;
    logic scm_change;
    logic rst_act_reg;
    logic [7:0] rst_cnt_reg;
    logic rst_start;
    logic [7:0] rst_len_reg;

    // watchdog enable and two-write service detection
    assign wdog_en = (wdog_rate_i != 3'h0);
    assign wdog_service = watchdog_arm_wr_i && wdog_armed_reg &&
        (watchdog_arm_data_i == WDOG_KEY2);

    // arm state: first key arms, anything else disarms
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdog_armed_reg <= 1'b0;
        end else if (watchdog_arm_wr_i) begin
            wdog_armed_reg <= (watchdog_arm_data_i == WDOG_KEY1);
        end
    end

    // watchdog period, restarted by a complete service
    crw_timer #(.W(TMR_W)) u_wdog_tmr (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .restart_i(!wdog_en || wdog_service || rst_act_reg),
        .run_i(wdog_en),
        .limit_i(WDOG_UNIT << wdog_rate_i),
        .expire_o(wdog_expire),
        .count_o(wdog_count)
    );

    // tick runs in run mode, or in pseudo-stop when kept
    assign tick_run = (tick_rate_i != 4'h0) && (!stop_mode_i ||
        (pseudo_stop_select_i && tick_keep_i));

    crw_timer #(.W(TMR_W)) u_tick_tmr (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .restart_i(tick_rate_i == 4'h0),
        .run_i(tick_run),
        .limit_i(TICK_UNIT << tick_rate_i),
        .expire_o(tick_expire),
        .count_o(tick_count)
    );

    // tick flag and masked request
    crw_flag u_tick_flag (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .set_i(tick_expire),
        .clr_i(periodic_tick_flag_clr_i),
        .en_i(periodic_tick_irq_enable_i),
        .flag_o(periodic_tick_flag_o),
        .irq_o(periodic_tick_irq_o)
    );

    // lock change in either direction
    assign lock_change = pll_lock_i ^ lock_prev_reg;

    crw_flag u_lock_flag (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .set_i(lock_change),
        .clr_i(lock_change_flag_clr_i),
        .en_i(lock_change_irq_enable_i),
        .flag_o(lock_change_flag_o),
        .irq_o(lock_change_irq_o)
    );

    // self-clock change flag, entry and exit alike
    assign scm_change = (scm_set && !scm_reg) || (scm_clr && !scm_set &&
        scm_reg);

    crw_flag u_scm_flag (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .set_i(scm_change),
        .clr_i(self_clock_change_flag_clr_i),
        .en_i(self_clock_irq_enable_i),
        .flag_o(self_clock_change_flag_o),
        .irq_o(self_clock_irq_o)
    );

    // previous levels for lock and oscillator edge detection
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_prev_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            lock_prev_reg <= pll_lock_i;
            osc_prev_reg <= osc_clock_i;
        end
    end

    // clock monitor: cycles since the last oscillator edge
    assign osc_edge = osc_clock_i ^ osc_prev_reg;
    assign cm_fail = clock_monitor_enable_i &&
        (cm_cnt_reg >= CM_DELAY_CYC);
    assign cm_event = cm_fail && !cm_fail_prev_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cm_cnt_reg <= 16'h0000;
            cm_fail_prev_reg <= 1'b0;
        end else begin
            cm_fail_prev_reg <= cm_fail;
            if (!clock_monitor_enable_i || osc_edge) begin
                cm_cnt_reg <= 16'h0000;
            end else if (cm_cnt_reg < CM_DELAY_CYC) begin
                cm_cnt_reg <= cm_cnt_reg + 16'h0001;
            end
        end
    end

    // quality check window
    assign qc_start = por_event_i || undervoltage_reset_i ||
        stop_recover_i || (cm_event && self_clock_mode_enable_i);

    crw_timer #(.W(TMR_W)) u_qc_tmr (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .restart_i(qc_start),
        .run_i(qc_state_reg == QC_RUN),
        .limit_i(QC_WINDOW_CYC),
        .expire_o(qc_win_end),
        .count_o()
    );

    assign qc_valid = (qc_edges_reg >= QC_MIN_EDGES);
    assign qc_last_fail = qc_win_end && !qc_valid &&
        (qc_win_reg == QC_MAX_WINDOWS - 6'h01);

    // quality check sequencing, keeps checking after giving up
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            qc_state_reg <= QC_IDLE;
            qc_pend_reg <= 1'b0;
            qc_edges_reg <= 8'h00;
            qc_win_reg <= 6'h00;
        end else begin
            case (qc_state_reg)
                QC_IDLE: begin
                    if (qc_start) begin
                        qc_state_reg <= QC_RUN;
                    end
                end
                QC_RUN: begin
                    if (qc_win_end && qc_valid && !qc_start) begin
                        qc_state_reg <= QC_IDLE;
                    end
                end
                default: begin
                    qc_state_reg <= QC_IDLE;
                end
            endcase
            if (qc_start) begin
                qc_pend_reg <= qc_pend_reg || por_event_i ||
                    undervoltage_reset_i;
            end else if ((qc_win_end && qc_valid) || qc_last_fail) begin
                qc_pend_reg <= 1'b0;
            end
            if (qc_start || qc_win_end) begin
                qc_edges_reg <= 8'h00;
            end else if (osc_edge && !qc_valid) begin
                qc_edges_reg <= qc_edges_reg + 8'h01;
            end
            if (qc_start) begin
                qc_win_reg <= 6'h00;
            end else if (qc_win_end && !qc_valid &&
                    qc_win_reg != QC_MAX_WINDOWS - 6'h01) begin
                qc_win_reg <= qc_win_reg + 6'h01;
            end
        end
    end

    // self-clock entry and exit
    assign scm_set = qc_last_fail ||
        (cm_event && self_clock_mode_enable_i);
    assign scm_clr = qc_win_end && qc_valid;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scm_reg <= 1'b0;
        end else if (scm_set) begin
            scm_reg <= 1'b1;
        end else if (scm_clr) begin
            scm_reg <= 1'b0;
        end
    end

    // reset sequence triggers
    assign rst_start = !rst_act_reg && (wdog_expire ||
        (cm_event && !self_clock_mode_enable_i) ||
        (qc_pend_reg && ((qc_win_end && qc_valid) ||
        qc_last_fail)) || !reset_pin_i);

    // reset pin low for the fixed sequence length
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_act_reg <= 1'b0;
            rst_cnt_reg <= 8'h00;
        end else if (rst_start) begin
            rst_act_reg <= 1'b1;
            rst_cnt_reg <= 8'h00;
        end else if (rst_act_reg) begin
            rst_cnt_reg <= rst_cnt_reg + 8'h01;
            if (rst_cnt_reg == RST_TOTAL_CYC - 8'h01) begin
                rst_act_reg <= 1'b0;
            end
        end
    end

    // registered reset cause pulses
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdog_timeout_reg <= 1'b0;
            cm_reset_reg <= 1'b0;
        end else begin
            wdog_timeout_reg <= wdog_expire;
            cm_reset_reg <= cm_event && !self_clock_mode_enable_i;
        end
    end

    // outputs
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe_o = rst_act_reg;
    assign wdog_timeout_o = wdog_timeout_reg;
    assign clock_monitor_reset_o = cm_reset_reg;
    assign clock_monitor_fail_o = cm_fail;
    assign self_clock_mode_o = scm_reg;
    assign quality_check_busy_o = (qc_state_reg == QC_RUN);

    // helper: length of the last reset drive
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_len_reg <= 8'h00;
        end else if (!rst_act_reg) begin
            rst_len_reg <= 8'h00;
        end else begin
            rst_len_reg <= rst_len_reg + 8'h01;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    AST_WDOG_RESTART: assert property (
        wdog_service && wdog_en |=> wdog_count == '0)
        else $error("watchdog period not restarted by service");
    AST_WDOG_TIMEOUT: assert property (
        wdog_expire |=> rst_act_reg && wdog_timeout_o)
        else $error("watchdog expiry did not reset");
    AST_QC_VALID: assert property (
        qc_pend_reg && qc_win_end && qc_valid && !qc_start
        |=> rst_act_reg && !scm_reg)
        else $error("valid clock did not start reset on oscillator");
    AST_QC_GIVEUP: assert property (
        qc_pend_reg && qc_last_fail |=> rst_act_reg && scm_reg)
        else $error("fifty failed windows did not enter self-clock");
    AST_TICK_MASK: assert property (
        tick_expire |=> periodic_tick_flag_o &&
        periodic_tick_irq_o == periodic_tick_irq_enable_i)
        else $error("tick request wrong after expiry");
    AST_TICK_PSTOP: assert property (
        stop_mode_i && pseudo_stop_select_i && tick_keep_i &&
        tick_rate_i != 4'h0 && !tick_expire
        |=> tick_count == $past(tick_count) + 24'h000001)
        else $error("tick halted in pseudo-stop");
    AST_LOCK_FLAG: assert property (
        $changed(pll_lock_i) |=> lock_change_flag_o)
        else $error("lock change not flagged");
    AST_SCM_FLAG: assert property (
        $changed(scm_reg) |-> self_clock_change_flag_o)
        else $error("self-clock change not flagged");
    AST_CM_SCM: assert property (
        cm_event && self_clock_mode_enable_i |=> scm_reg)
        else $error("monitor failure did not enter self-clock");
    AST_CM_OFF: assert property (
        !clock_monitor_enable_i |-> !clock_monitor_fail_o ##1
        cm_cnt_reg == 16'h0000)
        else $error("monitor failure while disabled");
    AST_CM_NORESET: assert property (
        cm_event && self_clock_mode_enable_i && !rst_act_reg &&
        !wdog_expire && reset_pin_i && !qc_pend_reg |=> !rst_act_reg)
        else $error("monitor failure reset in self-clock mode");
    AST_RST_LEN: assert property (
        $fell(rst_act_reg) |-> rst_len_reg == RST_TOTAL_CYC)
        else $error("reset drive length wrong");

    COV_WDOG: cover property (wdog_expire);
    COV_SCM: cover property ($rose(scm_reg));
    COV_TICK: cover property (periodic_tick_irq_o);
    COV_LOCK: cover property (lock_change_irq_o);
endmodule : crw_core

// *** bench/tb.sv ***
`timescale 1ns/10ps
module tb import crw_pkg::*;;
    // clock, reset and stimulus
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic por_event_i, undervoltage_reset_i, stop_recover_i, stop_mode_i;
    logic pseudo_stop_select_i, watchdog_arm_wr_i, tick_keep_i;
    logic [2:0] wdog_rate_i;
    logic [7:0] watchdog_arm_data_i;
    logic [3:0] tick_rate_i;
    logic periodic_tick_irq_enable_i, periodic_tick_flag_clr_i, pll_lock_i;
    logic lock_change_irq_enable_i, lock_change_flag_clr_i;
    logic osc_clock_i = 1'b0;
    logic clock_monitor_enable_i, self_clock_mode_enable_i;
    logic self_clock_irq_enable_i, self_clock_change_flag_clr_i;
    // observed outputs
    logic reset_pin_o, reset_pin_oe_o, wdog_timeout_o, periodic_tick_flag_o;
    logic periodic_tick_irq_o, lock_change_flag_o, lock_change_irq_o;
    logic self_clock_change_flag_o, self_clock_irq_o, self_clock_mode_o;
    logic clock_monitor_fail_o, clock_monitor_reset_o, quality_check_busy_o;
    // bench state
    logic osc_run, ext_low;
    wire reset_pin_i;
    int err_total, compares, cyc, n, n_to;

    // pin has a pull-up; low when device drives or outside pulls
    assign reset_pin_i = ~((reset_pin_oe_o & ~reset_pin_o) | ext_low);

    crw_core #(.WDOG_UNIT(24'h000010), .TICK_UNIT(24'h000010)) i_dut (
        .mclk_i, .rstn_i, .por_event_i, .undervoltage_reset_i,
        .stop_recover_i, .stop_mode_i, .pseudo_stop_select_i,
        .reset_pin_i, .reset_pin_o, .reset_pin_oe_o, .wdog_rate_i,
        .watchdog_arm_wr_i, .watchdog_arm_data_i, .wdog_timeout_o,
        .tick_rate_i, .tick_keep_i, .periodic_tick_irq_enable_i,
        .periodic_tick_flag_clr_i, .periodic_tick_flag_o,
        .periodic_tick_irq_o, .pll_lock_i, .lock_change_irq_enable_i,
        .lock_change_flag_clr_i, .lock_change_flag_o, .lock_change_irq_o,
        .osc_clock_i, .clock_monitor_enable_i, .self_clock_mode_enable_i,
        .self_clock_irq_enable_i, .self_clock_change_flag_clr_i,
        .self_clock_change_flag_o, .self_clock_irq_o, .self_clock_mode_o,
        .clock_monitor_fail_o, .clock_monitor_reset_o, .quality_check_busy_o
    );

    // clock and oscillator stand-in
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (osc_run) osc_clock_i <= ~osc_clock_i;

    // count watchdog timeouts; hang guard
    always @(posedge mclk_i) begin
        if (wdog_timeout_o === 1'b1) n_to++;
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            results();
        end
    end

    // pick an output by index for waiting
    function automatic logic sig(input int s);
        case (s)
            0: return reset_pin_oe_o;
            1: return periodic_tick_flag_o;
            2: return quality_check_busy_o;
            3: return self_clock_mode_o;
            4: return wdog_timeout_o;
            5: return clock_monitor_fail_o;
            default: return lock_change_flag_o;
        endcase
    endfunction : sig

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic step(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask : step

    // bounded wait for an output level, c = edges waited
    task automatic wait_for(input int s, input logic l, input int lim,
                            output int c);
        c = 0;
        while (sig(s) !== l && c < lim) begin
            step(1);
            c++;
        end
        chk($sformatf("wait_%0d", s), 32'(l), 32'(sig(s)));
    endtask : wait_for

    // reset drive must stand for exactly its full length
    task automatic rst_len(input int lim);
        int c;
        #1;
        wait_for(0, 1'b1, lim, c);
        chk("pin_low", 0, reset_pin_i);
        c = 0;
        while (reset_pin_oe_o === 1'b1 && c < 300) begin
            step(1);
            c++;
        end
        chk("drive_len", 32'(RST_TOTAL_CYC), 32'(c));
    endtask : rst_len

    task automatic wd(input logic [7:0] d);
        @(posedge mclk_i);
        watchdog_arm_wr_i <= 1'b1;
        watchdog_arm_data_i <= d;
        @(posedge mclk_i);
        watchdog_arm_wr_i <= 1'b0;
        #1;
    endtask : wd

    // one-cycle pulse: events and write-one clears
    task automatic pulse(input int s);
        for (int i = 1; i >= 0; i--) begin
            @(posedge mclk_i);
            case (s)
                0: por_event_i <= 1'(i);
                1: undervoltage_reset_i <= 1'(i);
                2: stop_recover_i <= 1'(i);
                3: periodic_tick_flag_clr_i <= 1'(i);
                4: lock_change_flag_clr_i <= 1'(i);
                default: self_clock_change_flag_clr_i <= 1'(i);
            endcase
        end
        #1;
    endtask : pulse

    task automatic results;
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // main sequence
    initial begin
        {por_event_i, undervoltage_reset_i, stop_recover_i, stop_mode_i} = 0;
        {pseudo_stop_select_i, watchdog_arm_wr_i, tick_keep_i} = 0;
        {wdog_rate_i, watchdog_arm_data_i, tick_rate_i} = 0;
        {periodic_tick_irq_enable_i, periodic_tick_flag_clr_i} = 0;
        {pll_lock_i, lock_change_irq_enable_i, lock_change_flag_clr_i} = 0;
        {clock_monitor_enable_i, self_clock_mode_enable_i} = 0;
        {self_clock_irq_enable_i, self_clock_change_flag_clr_i} = 0;
        {osc_run, ext_low} = 0;
        repeat (16) @(posedge mclk_i);
        rstn_i <= 1'b1;
        osc_run <= 1'b1;
        step(1);
        chk("flags", 0, {periodic_tick_flag_o, lock_change_flag_o,
                         self_clock_change_flag_o, reset_pin_oe_o});
        // power-up and undervoltage: good clock, reset on oscillator
        pulse(0);
        chk("busy", 1, quality_check_busy_o);
        rst_len(500);
        chk("scm", 0, self_clock_mode_o);
        pulse(1);
        rst_len(500);
        // stop recovery runs a check but no reset
        pulse(2);
        wait_for(2, 1'b0, 500, n);
        chk("no_drive", 0, reset_pin_oe_o);
        // pin pulled low from outside
        @(posedge mclk_i);
        ext_low <= 1'b1;
        @(posedge mclk_i);
        ext_low <= 1'b0;
        rst_len(3);
        // periodic tick: period 32 cycles
        @(posedge mclk_i);
        tick_rate_i <= 4'h1;
        periodic_tick_irq_enable_i <= 1'b1;
        wait_for(1, 1'b1, 40, n);
        chk("tick_irq", 1, periodic_tick_irq_o);
        pulse(3);
        chk("tick_clr", 0, periodic_tick_flag_o);
        wait_for(1, 1'b1, 40, n);
        chk("tick_period", 1, 32'(n >= 29 && n <= 31));
        @(posedge mclk_i);
        periodic_tick_irq_enable_i <= 1'b0;
        step(1);
        chk("tick_mask", 0, periodic_tick_irq_o);
        pulse(3);
        @(posedge mclk_i);
        stop_mode_i <= 1'b1;
        pseudo_stop_select_i <= 1'b1;
        step(80);
        chk("tick_stop", 0, periodic_tick_flag_o);
        @(posedge mclk_i);
        tick_keep_i <= 1'b1;
        wait_for(1, 1'b1, 40, n);
        @(posedge mclk_i);
        stop_mode_i <= 1'b0;
        tick_rate_i <= 4'h0;
        pulse(3);
        // lock change both ways, set beats clear
        @(posedge mclk_i);
        lock_change_irq_enable_i <= 1'b1;
        pll_lock_i <= 1'b1;
        wait_for(7, 1'b1, 3, n);
        chk("lock_irq", 1, lock_change_irq_o);
        pulse(4);
        chk("lock_clr", 0, lock_change_flag_o);
        @(posedge mclk_i);
        pll_lock_i <= 1'b0;
        lock_change_flag_clr_i <= 1'b1;
        @(posedge mclk_i);
        lock_change_flag_clr_i <= 1'b0;
        lock_change_irq_enable_i <= 1'b0;
        step(1);
        chk("lock_set_wins", 1, lock_change_flag_o);
        chk("lock_mask", 0, lock_change_irq_o);
        pulse(4);
        // watchdog: period 32, kept alive, then a broken service
        @(posedge mclk_i);
        wdog_rate_i <= 3'h1;
        n = n_to;
        repeat (4) begin
            wd(WDOG_KEY1);
            wd(WDOG_KEY2);
            step(20);
        end
        chk("wdog_alive", n, n_to);
        wd(WDOG_KEY2);
        wd(WDOG_KEY1);
        wd(8'h12);
        wd(WDOG_KEY2);
        wait_for(4, 1'b1, 8, n);
        rst_len(2);
        @(posedge mclk_i);
        wdog_rate_i <= 3'h0;
        // monitor failure without self-clock gives a reset
        osc_run <= 1'b0;
        clock_monitor_enable_i <= 1'b1;
        wait_for(5, 1'b1, 260, n);
        chk("cm_delay", 1, 32'(n >= 195 && n <= 203));
        step(1);
        chk("cm_reset", 1, clock_monitor_reset_o);
        rst_len(2);
        @(posedge mclk_i);
        clock_monitor_enable_i <= 1'b0;
        step(1);
        chk("cm_off", 0, clock_monitor_fail_o);
        // with self-clock enabled: enter self-clock, no reset
        @(posedge mclk_i);
        self_clock_mode_enable_i <= 1'b1;
        self_clock_irq_enable_i <= 1'b1;
        clock_monitor_enable_i <= 1'b1;
        wait_for(3, 1'b1, 260, n);
        step(1);
        chk("sc_no_drive", 0, reset_pin_oe_o);
        chk("sc_flag", 1, self_clock_change_flag_o);
        chk("sc_irq", 1, self_clock_irq_o);
        pulse(5);
        chk("sc_clr", 0, self_clock_change_flag_o);
        @(posedge mclk_i);
        osc_run <= 1'b1;
        wait_for(5, 1'b0, 3, n);
        wait_for(3, 1'b0, 900, n);
        step(1);
        chk("sc_exit_flag", 1, self_clock_change_flag_o);
        @(posedge mclk_i);
        self_clock_irq_enable_i <= 1'b0;
        step(1);
        chk("sc_mask", 0, self_clock_irq_o);
        pulse(5);
        // dead oscillator at power-up: fifty windows, then self-clock
        @(posedge mclk_i);
        osc_run <= 1'b0;
        clock_monitor_enable_i <= 1'b0;
        pulse(0);
        wait_for(3, 1'b1, 21000, n);
        chk("qc_windows", 1, 32'(n >= int'(QC_MAX_WINDOWS) *
            int'(QC_WINDOW_CYC) - 5 && n <= int'(QC_MAX_WINDOWS) *
            int'(QC_WINDOW_CYC) + 5));
        rst_len(3);
        @(posedge mclk_i);
        osc_run <= 1'b1;
        wait_for(3, 1'b0, 900, n);
        results();
    end
endmodule : tb
